/* File: design/bppt_core.sv */
// complementary bridge pwm with dead time, phase shift, phase detect and timer
// Function
// - Twelve-bit counter drives complementary outputs; period sets frequency, duty sets width.
// - Separate flags set on duty match and on period match.
// - Period, duty, delay and dead-time writes buffered, loaded when counter is zero.
// - Dead time is setting plus one cycles, gated by dead-time enable.
// - Main rising edges delayed by dead time 0, complement by dead time 1.
// - At generator start with dead time on, first main rise is undelayed.
// - Enabling dead time acts next rise; disabling stops it at once.
// - Phase-shift delay is eleven-bit setting plus one cycles.
// - Second pair copies first pair with rising edges delayed by phase shift.
// - Phase shift acts only when its control enable bit is set.
// - Phase-shift enable takes effect only after current period ends.
// - Detector 0 compares main with comparator 0, detector 1 complement with 1.
// - Phase signal high while current lags voltage, low with no difference.
// - Voltage lagging current gives no width and raises protection flag.
// - Ten-bit up timer clocked by divided, fast, slow or event edges.
// - Timer count and capture cleared only when run bit rises.
// - Timer mode counts 0 to 1023 and flags overflow on 1023.
// - Timer mode: wait elapsed latches count, flags capture, clears run.
// - Capture mode uses phase signal with rising, falling or both edges.
// - Capture mode latches count on each edge; counter runs until stop.
`timescale 1ns/1ps
module bppt_core #(
  parameter int unsigned WAIT_UNIT = bppt_pkg::WAIT_UNIT
) (
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     reset,
  // register port
  input  wire logic [bppt_pkg::AW-1:0]  addr,
  input  wire logic [bppt_pkg::DW-1:0]  wdata,
  input  wire logic                     wr,
  input  wire logic                     rd,
  output logic      [bppt_pkg::DW-1:0]  rdata,
  // comparator and slow clock inputs
  input  wire logic                     currentCmp0Out,
  input  wire logic                     currentCmp1Out,
  input  wire logic                     lowSpeedTick,
  // bridge outputs
  output logic                          pairAMainOut,
  output logic                          pairACompOut,
  output logic                          pairBMainOut,
  output logic                          pairBCompOut,
  // phase detector outputs
  output logic                          phaseSig0,
  output logic                          phaseSig1
);
  localparam int unsigned PW = bppt_pkg::PW;
  localparam int unsigned TW = bppt_pkg::TW;
  localparam int unsigned WW = bppt_pkg::WW;
  localparam int unsigned NST = bppt_pkg::NST;
  localparam int unsigned DW = bppt_pkg::DW;

  logic [bppt_pkg::CTRL_W-1:0]  ctrl_r;
  logic [PW-1:0]                perBuf_r, dutyBuf_r, dead0Buf_r, dead1Buf_r;
  logic [bppt_pkg::SW-1:0]      psdBuf_r, psdAct_r;
  logic [PW-1:0]                perAct_r, dutyAct_r, dead0Act_r, dead1Act_r;
  logic [PW-1:0]                cnt_r, cnt_nxt;
  logic                         psEff_r;
  logic [bppt_pkg::TCTRL_W-1:0] tctrl_r;
  logic                         run_nxt, runRise;
  logic [TW-1:0]                tcnt_r, tcnt_nxt, capt_r, capt_nxt;
  logic [WW-1:0]                wait_r, waitLen;
  logic [5:0]                   presc_r;
  logic [NST-1:0]               stat_r, stSet, stClr;
  logic [bppt_pkg::DW-1:0]      rdata_r, rdMux;
  logic [1:0]                   phase_r, phPrev_r, evPrev_r, prot, vPrev;
  logic [3:0]                   uIn, uEn, uOut;
  logic [PW-1:0]                uDly [4];

  // address decode
  wire wCtrl  = wr && addr == bppt_pkg::A_CTRL;
  wire wPer   = wr && addr == bppt_pkg::A_PERIOD;
  wire wDuty  = wr && addr == bppt_pkg::A_DUTY;
  wire wDead0 = wr && addr == bppt_pkg::A_DEAD0;
  wire wDead1 = wr && addr == bppt_pkg::A_DEAD1;
  wire wPsd   = wr && addr == bppt_pkg::A_PSD;
  wire wTctrl = wr && addr == bppt_pkg::A_TCTRL;
  wire wStat  = wr && addr == bppt_pkg::A_STAT;

  wire genOn = ctrl_r[bppt_pkg::C_ON];
  wire deadOn = ctrl_r[bppt_pkg::C_DEAD];
  wire atZero = cnt_r == '0;
  wire atPer = cnt_r == perAct_r;

  // pwm counter
  assign cnt_nxt = (!genOn || atPer) ? '0 : cnt_r + 1'b1;
  wire rawMain = genOn && cnt_r <= dutyAct_r;
  wire rawComp = genOn && !(cnt_r <= dutyAct_r);

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      cnt_r <= '0;
      perAct_r <= bppt_pkg::PER_RST;
      dutyAct_r <= bppt_pkg::DUTY_RST;
      dead0Act_r <= bppt_pkg::DT_RST;
      dead1Act_r <= bppt_pkg::DT_RST;
      psdAct_r <= bppt_pkg::PSD_RST;
      psEff_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      if (atZero)
      begin
        perAct_r <= perBuf_r;
        dutyAct_r <= dutyBuf_r;
        dead0Act_r <= dead0Buf_r;
        dead1Act_r <= dead1Buf_r;
        psdAct_r <= psdBuf_r;
      end
      if (!genOn || atPer)
        psEff_r <= ctrl_r[bppt_pkg::C_PSE];
    end
  end

  // software registers
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ctrl_r <= '0;
      perBuf_r <= bppt_pkg::PER_RST;
      dutyBuf_r <= bppt_pkg::DUTY_RST;
      dead0Buf_r <= bppt_pkg::DT_RST;
      dead1Buf_r <= bppt_pkg::DT_RST;
      psdBuf_r <= bppt_pkg::PSD_RST;
      tctrl_r <= '0;
    end
    else
    begin
      if (wCtrl) ctrl_r <= wdata[bppt_pkg::CTRL_W-1:0];
      if (wPer) perBuf_r <= wdata[PW-1:0];
      if (wDuty) dutyBuf_r <= wdata[PW-1:0];
      if (wDead0) dead0Buf_r <= wdata[PW-1:0];
      if (wDead1) dead1Buf_r <= wdata[PW-1:0];
      if (wPsd) psdBuf_r <= wdata[bppt_pkg::SW-1:0];
      tctrl_r <= {(wTctrl ? wdata[bppt_pkg::TCTRL_W-1:1] : tctrl_r[bppt_pkg::TCTRL_W-1:1]),
                  run_nxt};
    end
  end

  // rising-edge delay units: 0/1 dead time on pair a, 2/3 phase shift to pair b
  assign uIn = {uOut[1], uOut[0], rawComp, rawMain};
  assign uEn = {psEff_r, psEff_r, deadOn, deadOn};
  assign uDly[0] = dead0Act_r;
  assign uDly[1] = dead1Act_r;
  assign uDly[2] = {1'b0, psdAct_r};
  assign uDly[3] = {1'b0, psdAct_r};

  genvar g;
  generate
    for (g = 0; g < bppt_pkg::NDLY; g++)
    begin : gDly
      logic          out_r, busy_r, prev_r, skip_r, rise, fire;
      logic [PW-1:0] dc_r;
      assign rise = uIn[g] && !prev_r;
      assign fire = busy_r && dc_r == '0;
      always_ff @(posedge mclk)
      begin
        if (reset)
        begin
          out_r <= 1'b0;
          busy_r <= 1'b0;
          prev_r <= 1'b0;
          skip_r <= 1'b0;
          dc_r <= '0;
        end
        else
        begin
          prev_r <= uIn[g];
          skip_r <= (g == 0) && (!genOn || (skip_r && !rise));
          if (!uEn[g] || !uIn[g])
            busy_r <= 1'b0;
          else if (rise && !(skip_r && deadOn))
            busy_r <= 1'b1;
          else if (fire)
            busy_r <= 1'b0;
          dc_r <= rise ? uDly[g] : (busy_r ? dc_r - 1'b1 : dc_r);
          if (!uIn[g])
            out_r <= 1'b0;
          else if (!uEn[g] || (rise && skip_r))
            out_r <= 1'b1;
          else
            out_r <= out_r || fire;
        end
      end
      assign uOut[g] = out_r;
      AST_DT_HOLD: assert property (@(posedge mclk) disable iff (reset)
        uEn[g] && busy_r && dc_r != '0 |=> !out_r)
        else $error("delayed output rose before its delay ran out");
      AST_DT_OFF: assert property (@(posedge mclk) disable iff (reset)
        !uEn[g] |=> out_r == $past(uIn[g]))
        else $error("disabled delay unit did not pass its input");
    end
  endgenerate

  assign pairAMainOut = uOut[0];
  assign pairACompOut = uOut[1];
  assign pairBMainOut = uOut[2];
  assign pairBCompOut = uOut[3];

  // phase detectors: phase high while voltage up and current not yet
  wire [1:0] vSig = {uOut[1], uOut[0]};
  wire [1:0] iSig = {currentCmp1Out, currentCmp0Out};
  assign prot = vSig & ~phPrev_r & iSig & ~{phaseSig1, phaseSig0} & ~vPrev;
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      phase_r <= '0;
      vPrev <= '0;
    end
    else
    begin
      phase_r <= vSig & ~iSig;
      vPrev <= vSig;
    end
  end
  assign phaseSig0 = phase_r[0];
  assign phaseSig1 = phase_r[1];

  // timer clock select
  wire evSig = tctrl_r[bppt_pkg::T_EVS] ? currentCmp1Out : currentCmp0Out;
  wire evPrev = tctrl_r[bppt_pkg::T_EVS] ? evPrev_r[1] : evPrev_r[0];
  wire [2:0] cks = tctrl_r[bppt_pkg::T_CKS +: 3];
  wire tick = (cks == bppt_pkg::K_DIV1) || (cks == bppt_pkg::K_FH)
    || (cks == bppt_pkg::K_DIV4 && presc_r[1:0] == bppt_pkg::M_DIV4[1:0])
    || (cks == bppt_pkg::K_DIV16 && presc_r[3:0] == bppt_pkg::M_DIV16[3:0])
    || (cks == bppt_pkg::K_DIV64 && presc_r == bppt_pkg::M_DIV64)
    || (cks == bppt_pkg::K_FSUB && lowSpeedTick)
    || (cks == bppt_pkg::K_EVR && evSig && !evPrev)
    || (cks == bppt_pkg::K_EVF && !evSig && evPrev);

  // timer control
  wire runOn = tctrl_r[bppt_pkg::T_RUN];
  wire tmrMode = tctrl_r[bppt_pkg::T_MODE + 1];
  wire [1:0] edg = tctrl_r[bppt_pkg::T_EDGE +: 2];
  wire capSel = tctrl_r[bppt_pkg::T_CAPS];
  wire phNow = capSel ? phase_r[1] : phase_r[0];
  wire phOld = capSel ? phPrev_r[1] : phPrev_r[0];
  wire phRise = phNow && !phOld;
  wire phFall = !phNow && phOld;
  wire capEv = runOn && !tmrMode && ((edg == bppt_pkg::E_RISE) ? phRise :
    (edg == bppt_pkg::E_FALL) ? phFall : (phRise || phFall));
  assign waitLen = WW'(WAIT_UNIT) << tctrl_r[bppt_pkg::T_WAIT +: 3];
  wire waitDone = runOn && tmrMode && wait_r == waitLen - 1'b1;
  assign run_nxt = wTctrl ? wdata[bppt_pkg::T_RUN] : (runOn && !waitDone);
  assign runRise = run_nxt && !runOn;
  assign tcnt_nxt = runRise ? '0 : ((runOn && tick) ? tcnt_r + 1'b1 : tcnt_r);
  assign capt_nxt = runRise ? '0 : ((waitDone || capEv) ? tcnt_r : capt_r);

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      tcnt_r <= '0;
      capt_r <= '0;
      wait_r <= '0;
      presc_r <= '0;
      phPrev_r <= '0;
      evPrev_r <= '0;
    end
    else
    begin
      tcnt_r <= tcnt_nxt;
      capt_r <= capt_nxt;
      wait_r <= (runOn && !runRise) ? wait_r + 1'b1 : '0;
      presc_r <= presc_r + 1'b1;
      phPrev_r <= phase_r;
      evPrev_r <= iSig;
    end
  end

  // sticky status, write one to clear, set beats clear
  assign stSet[bppt_pkg::S_DUTY] = genOn && cnt_r == dutyAct_r;
  assign stSet[bppt_pkg::S_PER] = genOn && atPer;
  assign stSet[bppt_pkg::S_OVF] = runOn && tmrMode && tick
    && tcnt_r == bppt_pkg::T_MAX - 1'b1;
  assign stSet[bppt_pkg::S_CAP] = waitDone || capEv;
  assign stSet[bppt_pkg::S_PRT1:bppt_pkg::S_PRT0] = prot;
  assign stClr = wStat ? wdata[NST-1:0] : '0;

  // read mux
  assign rdMux = (addr == bppt_pkg::A_CTRL)   ? DW'(ctrl_r) :
                 (addr == bppt_pkg::A_PERIOD) ? DW'(perBuf_r) :
                 (addr == bppt_pkg::A_DUTY)   ? DW'(dutyBuf_r) :
                 (addr == bppt_pkg::A_DEAD0)  ? DW'(dead0Buf_r) :
                 (addr == bppt_pkg::A_DEAD1)  ? DW'(dead1Buf_r) :
                 (addr == bppt_pkg::A_PSD)    ? DW'(psdBuf_r) :
                 (addr == bppt_pkg::A_TCTRL)  ? DW'(tctrl_r) :
                 (addr == bppt_pkg::A_STAT)   ? DW'(stat_r) :
                 (addr == bppt_pkg::A_CAPT)   ? DW'(capt_r) :
                 (addr == bppt_pkg::A_TCNT)   ? DW'(tcnt_r) :
                 (addr == bppt_pkg::A_PCNT)   ? DW'(cnt_r) : '0;

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      stat_r <= '0;
      rdata_r <= '0;
    end
    else
    begin
      stat_r <= (stat_r & ~stClr) | stSet;
      rdata_r <= rd ? rdMux : '0;
    end
  end
  assign rdata = rdata_r;

  // checks
  sequence sRunStart;
    !runOn ##1 runOn;
  endsequence
  sequence sWaitEnd;
    waitDone && !wTctrl;
  endsequence

  AST_CNT_WRAP: assert property (@(posedge mclk) disable iff (reset)
    genOn && atPer |=> cnt_r == '0)
    else $error("pwm counter did not wrap after period");
  AST_LOAD: assert property (@(posedge mclk) disable iff (reset)
    !atZero |=> perAct_r == $past(perAct_r) && dutyAct_r == $past(dutyAct_r))
    else $error("active value changed away from counter zero");
  AST_DUTY_FLAG: assert property (@(posedge mclk) disable iff (reset)
    genOn && cnt_r == dutyAct_r |=> stat_r[bppt_pkg::S_DUTY])
    else $error("duty match flag not set");
  AST_NO_OVERLAP: assert property (@(posedge mclk) disable iff (reset)
    !(pairAMainOut && pairACompOut))
    else $error("main and complement high together");
  AST_PS_EDGE: assert property (@(posedge mclk) disable iff (reset)
    $changed(psEff_r) |-> $past(!genOn || atPer))
    else $error("phase shift enable changed inside a period");
  AST_PHASE_LOW: assert property (@(posedge mclk) disable iff (reset)
    currentCmp0Out |=> !phaseSig0)
    else $error("phase signal high with current already up");
  AST_RUN_CLR: assert property (@(posedge mclk) disable iff (reset)
    sRunStart |-> tcnt_r == '0 && capt_r == '0)
    else $error("timer not cleared at run start");
  AST_WAIT_END: assert property (@(posedge mclk) disable iff (reset)
    sWaitEnd |=> !runOn && stat_r[bppt_pkg::S_CAP] && capt_r == $past(tcnt_r))
    else $error("wait end did not capture and stop");
  AST_CAPTURE: assert property (@(posedge mclk) disable iff (reset)
    capEv && !runRise |=> capt_r == $past(tcnt_r) ##0 runOn || $past(wTctrl))
    else $error("capture edge did not latch counter");

  sequence sGenStart;
    !genOn ##1 genOn;
  endsequence
  AST_FIRST_RISE: assert property (@(posedge mclk) disable iff (reset)
    sGenStart ##0 deadOn |=> pairAMainOut)
    else $error("first main rise after start was delayed");
  AST_PER_FLAG: assert property (@(posedge mclk) disable iff (reset)
    genOn && atPer |=> stat_r[bppt_pkg::S_PER])
    else $error("period match flag not set");
  AST_OVF_FLAG: assert property (@(posedge mclk) disable iff (reset)
    stSet[bppt_pkg::S_OVF] |=> tcnt_r == bppt_pkg::T_MAX && stat_r[bppt_pkg::S_OVF])
    else $error("overflow flag not set at top count");
  AST_PAIR_B_COPY: assert property (@(posedge mclk) disable iff (reset)
    !psEff_r |=> pairBMainOut == $past(pairAMainOut) && pairBCompOut == $past(pairACompOut))
    else $error("second pair did not follow first pair with shift off");
  AST_PHASE_HIGH: assert property (@(posedge mclk) disable iff (reset)
    pairAMainOut && !currentCmp0Out |=> phaseSig0)
    else $error("phase signal low while current lags voltage");
  AST_PROT_FLAG: assert property (@(posedge mclk) disable iff (reset)
    $rose(pairAMainOut) && currentCmp0Out && !phaseSig0 && !$past(phaseSig0)
    |=> stat_r[bppt_pkg::S_PRT0])
    else $error("voltage lagging current did not raise protection");
endmodule

/* File: include/bppt_pkg.sv */
// constants, register map and field layout of the bridge pwm and phase timer
package bppt_pkg;
  localparam int unsigned AW = 8;
  localparam int unsigned DW = 32;
  localparam int unsigned PW = 12;
  localparam int unsigned SW = 11;
  localparam int unsigned TW = 10;
  localparam int unsigned WW = 18;
  localparam int unsigned NST = 6;
  localparam int unsigned NDLY = 4;
  // register byte addresses
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_PERIOD = 8'h04;
  localparam logic [7:0] A_DUTY   = 8'h08;
  localparam logic [7:0] A_DEAD0  = 8'h0C;
  localparam logic [7:0] A_DEAD1  = 8'h10;
  localparam logic [7:0] A_PSD    = 8'h14;
  localparam logic [7:0] A_TCTRL  = 8'h18;
  localparam logic [7:0] A_STAT   = 8'h1C;
  localparam logic [7:0] A_CAPT   = 8'h20;
  localparam logic [7:0] A_TCNT   = 8'h24;
  localparam logic [7:0] A_PCNT   = 8'h28;
  // pwm_control_0 bits
  localparam int unsigned C_ON  = 0;
  localparam int unsigned C_DEAD = 1;
  localparam int unsigned C_PSE = 2;
  localparam int unsigned CTRL_W = 3;
  // timer_control fields
  localparam int unsigned T_RUN   = 0;
  localparam int unsigned T_MODE  = 1;
  localparam int unsigned T_EDGE  = 3;
  localparam int unsigned T_CKS   = 5;
  localparam int unsigned T_WAIT  = 8;
  localparam int unsigned T_CAPS  = 11;
  localparam int unsigned T_EVS   = 12;
  localparam int unsigned TCTRL_W = 13;
  // status flag positions
  localparam int unsigned S_DUTY = 0;
  localparam int unsigned S_PER  = 1;
  localparam int unsigned S_OVF  = 2;
  localparam int unsigned S_CAP  = 3;
  localparam int unsigned S_PRT0 = 4;
  localparam int unsigned S_PRT1 = 5;
  // capture edge codes
  localparam logic [1:0] E_RISE = 2'h0;
  localparam logic [1:0] E_FALL = 2'h1;
  // timer clock select codes
  localparam logic [2:0] K_DIV1 = 3'h0;
  localparam logic [2:0] K_DIV4 = 3'h1;
  localparam logic [2:0] K_DIV16 = 3'h2;
  localparam logic [2:0] K_DIV64 = 3'h3;
  localparam logic [2:0] K_FH   = 3'h4;
  localparam logic [2:0] K_FSUB = 3'h5;
  localparam logic [2:0] K_EVR  = 3'h6;
  localparam logic [2:0] K_EVF  = 3'h7;
  localparam logic [5:0] M_DIV4 = 6'h03;
  localparam logic [5:0] M_DIV16 = 6'h0F;
  localparam logic [5:0] M_DIV64 = 6'h3F;
  localparam logic [TW-1:0] T_MAX = 10'h3FF;
  // reset values
  localparam logic [PW-1:0] PER_RST  = 12'h0FF;
  localparam logic [PW-1:0] DUTY_RST = 12'h07F;
  localparam logic [PW-1:0] DT_RST   = 12'h000;
  localparam logic [SW-1:0] PSD_RST  = 11'h000;
  localparam int unsigned WAIT_UNIT = 1024;
endpackage

/* File: sim/bppt_resonant_model.sv */
// resonant current comparator model fed by the first bridge pair
`timescale 1ns/1ps
module bppt_resonant_model (
  // clock
  input  wire logic       mclk,
  // bridge outputs seen by the coil
  input  wire logic       mainIn,
  input  wire logic       compIn,
  // current lag in cycles, or current leading the voltage
  input  wire logic [3:0] lag,
  input  wire logic       leadMode,
  // comparator levels
  output logic            cmp0,
  output logic            cmp1
);
  logic [15:0] mainHist = 16'h0000;
  logic [15:0] compHist = 16'h0000;
  always_ff @(posedge mclk)
  begin
    mainHist <= {mainHist[14:0], mainIn};
    compHist <= {compHist[14:0], compIn};
  end
  // lag zero follows the output, lead mode holds the comparator high ahead of the rise
  assign cmp0 = leadMode ? 1'b1 : ((lag == 4'h0) ? mainIn : mainHist[lag - 4'h1]);
  assign cmp1 = leadMode ? 1'b1 : ((lag == 4'h0) ? compIn : compHist[lag - 4'h1]);
endmodule

/* File: sim/bppt_core_tb_top.sv */
// self-checking bench of the bridge pwm and phase timer
`timescale 1ns/1ps
module bppt_core_tb_top;
  logic        mclk;
  logic        reset;
  logic        wr;
  logic        rd;
  logic        leadMode;
  logic        lowSpeedTick = 1'b0;
  logic [2:0]  slowDiv = 3'h0;
  logic [3:0]  lag;
  logic [7:0]  addr;
  logic [31:0] wdata;
  wire  [31:0] rdata;
  wire         cmp0;
  wire         cmp1;
  wire  [5:0]  outs;
  int          miscompares = 0;
  int          n_checks = 0;
  int          cycles = 0;
  bppt_core #(.WAIT_UNIT(8)) dut (.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .currentCmp0Out(cmp0), .currentCmp1Out(cmp1),
    .lowSpeedTick(lowSpeedTick), .pairAMainOut(outs[0]), .pairACompOut(outs[1]),
    .pairBMainOut(outs[2]), .pairBCompOut(outs[3]), .phaseSig0(outs[4]), .phaseSig1(outs[5]));
  bppt_resonant_model coil (.mclk(mclk), .mainIn(outs[0]), .compIn(outs[1]), .lag(lag),
    .leadMode(leadMode), .cmp0(cmp0), .cmp1(cmp1));
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // slow clock tick every eight cycles
  always @(posedge mclk)
  begin
    slowDiv <= slowDiv + 3'h1;
    lowSpeedTick <= (slowDiv == 3'h7);
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  // high samples of one pulse and samples from its rise to the next rise
  task automatic measure(input int idx, output int hi, output int per);
    int n;
    for (n = 0; outs[idx] !== 1'b0 && n < 3000; n++) tick();
    for (n = 0; outs[idx] !== 1'b1 && n < 3000; n++) tick();
    for (hi = 0; outs[idx] === 1'b1 && hi < 3000; hi++) tick();
    for (per = hi; outs[idx] !== 1'b1 && per < 3000; per++) tick();
  endtask
  task automatic expect_width(input string name, input int idx, input int hi, input int per);
    int h;
    int p;
    measure(idx, h, p);
    measure(idx, h, p);
    check(name, 32'(h), 32'(hi));
    if (per > 0)
      check({name, " period"}, 32'(p), 32'(per));
  endtask
  task automatic t_reset();
    logic [31:0] d;
    check("outputs at reset", 32'(outs), 32'h0);
    rd_reg(bppt_pkg::A_PERIOD, d);
    check("period reset", d, 32'h0FF);
    rd_reg(bppt_pkg::A_DUTY, d);
    check("duty reset", d, 32'h07F);
    rd_reg(8'h3C, d);
    check("unmapped read", d, 32'h0);
  endtask
  task automatic t_pwm();
    logic [31:0] d;
    int bad;
    wr_reg(bppt_pkg::A_PERIOD, 32'h9);
    wr_reg(bppt_pkg::A_DUTY, 32'h4);
    wr_reg(bppt_pkg::A_CTRL, 32'h1);
    expect_width("main width", 0, 5, 10);
    expect_width("pair b main plain", 2, 5, 10);
    bad = 0;
    repeat (20)
    begin
      tick();
      bad += (outs[1] !== ~outs[0]);
    end
    check("comp inverse", 32'(bad), 32'h0);
    rd_reg(bppt_pkg::A_STAT, d);
    check("match flags", d[1:0], 32'h3);
    wr_reg(bppt_pkg::A_CTRL, 32'h0);
    wr_reg(bppt_pkg::A_STAT, 32'h3F);
    rd_reg(bppt_pkg::A_STAT, d);
    check("flags cleared", d[1:0], 32'h0);
    wr_reg(bppt_pkg::A_CTRL, 32'h1);
    wr_reg(bppt_pkg::A_PERIOD, 32'h13);
    rd_reg(bppt_pkg::A_PERIOD, d);
    check("period buffer", d, 32'h13);
    expect_width("new period", 0, 5, 20);
  endtask
  task automatic t_dead();
    int h0;
    int h1;
    int p;
    wr_reg(bppt_pkg::A_DEAD0, 32'h2);
    wr_reg(bppt_pkg::A_DEAD1, 32'h3);
    wr_reg(bppt_pkg::A_CTRL, 32'h3);
    expect_width("dead main", 0, 2, 20);
    expect_width("dead comp", 1, 11, 20);
    wr_reg(bppt_pkg::A_CTRL, 32'h1);
    expect_width("dead off", 0, 5, 20);
    wr_reg(bppt_pkg::A_CTRL, 32'h0);
    wr_reg(bppt_pkg::A_CTRL, 32'h2);
    fork
      wr_reg(bppt_pkg::A_CTRL, 32'h3);
      measure(0, h0, p);
      measure(1, h1, p);
    join
    check("first main", 32'(h0), 32'h5);
    check("first comp", 32'(h1), 32'hB);
    wr_reg(bppt_pkg::A_CTRL, 32'h1);
  endtask
  task automatic t_shift();
    wr_reg(bppt_pkg::A_PSD, 32'h2);
    wr_reg(bppt_pkg::A_CTRL, 32'h5);
    expect_width("shift main", 2, 2, 20);
    expect_width("shift comp", 3, 12, 20);
    wr_reg(bppt_pkg::A_CTRL, 32'h1);
    expect_width("shift off", 2, 5, 0);
  endtask
  task automatic t_phase();
    logic [31:0] d;
    int hi;
    lag <= 4'h3;
    expect_width("phase_sig_0", 4, 3, 20);
    expect_width("phase_sig_1", 5, 3, 20);
    lag <= 4'h0;
    repeat (4) tick();
    hi = 0;
    repeat (40)
    begin
      tick();
      hi += (outs[4] !== 1'b0);
    end
    check("phase no lag", 32'(hi), 32'h0);
    leadMode <= 1'b1;
    wr_reg(bppt_pkg::A_STAT, 32'h3F);
    repeat (45) tick();
    rd_reg(bppt_pkg::A_STAT, d);
    check("protect flag", d[bppt_pkg::S_PRT0], 32'h1);
    leadMode <= 1'b0;
  endtask
  // timer mode with wait select 3, 64 cycles
  task automatic t_timer();
    logic [31:0] d;
    int e;
    for (int k = 0; k < 8; k++)
    begin
      e = (k < 4) ? (64 >> (2 * k)) : ((k == 4) ? 64 : ((k == 5) ? 8 : 3));
      wr_reg(bppt_pkg::A_STAT, 32'h3F);
      wr_reg(bppt_pkg::A_TCTRL, 32'h0);
      wr_reg(bppt_pkg::A_TCTRL, 32'h1 | (32'h2 << 1) | (32'(k) << 5) | (32'h3 << 8)
        | (32'(k == 7) << bppt_pkg::T_EVS));
      rd_reg(bppt_pkg::A_TCNT, d);
      check("count cleared", 32'(d < 5), 32'h1);
      for (int n = 0; n < 100; n++)
      begin
        rd_reg(bppt_pkg::A_TCTRL, d);
        if (d[0] === 1'b0)
          break;
      end
      check("run cleared", d[0], 32'h0);
      rd_reg(bppt_pkg::A_CAPT, d);
      check("timer capture", 32'(d + 1 >= e && d <= e + 1), 32'h1);
      rd_reg(bppt_pkg::A_STAT, d);
      check("capture flag", d[bppt_pkg::S_CAP], 32'h1);
    end
    wr_reg(bppt_pkg::A_TCTRL, 32'h0);
    wr_reg(bppt_pkg::A_TCTRL, 32'h1 | (32'h3 << 1) | (32'h7 << 8));
    repeat (1100) tick();
    rd_reg(bppt_pkg::A_STAT, d);
    check("overflow flag", d[bppt_pkg::S_OVF], 32'h1);
  endtask
  task automatic t_capture();
    logic [31:0] a;
    logic [31:0] b;
    lag <= 4'h3;
    for (int e = 0; e < 3; e++)
    begin
      wr_reg(bppt_pkg::A_STAT, 32'h3F);
      wr_reg(bppt_pkg::A_TCTRL, 32'h0);
      wr_reg(bppt_pkg::A_TCTRL, 32'h1 | (32'(e == 1) << 1) | (32'(e) << 3)
        | (32'(e == 2) << bppt_pkg::T_CAPS));
      repeat (50) tick();
      rd_reg(bppt_pkg::A_STAT, a);
      check("edge capture", a[bppt_pkg::S_CAP], 32'h1);
      rd_reg(bppt_pkg::A_TCNT, a);
      rd_reg(bppt_pkg::A_TCNT, b);
      check("free run", 32'(b > a), 32'h1);
    end
    wr_reg(bppt_pkg::A_TCTRL, 32'h0);
  endtask
  initial
  begin
    reset = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    lag = 4'h0;
    leadMode = 1'b0;
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    #1;
    t_reset();
    t_pwm();
    t_dead();
    t_shift();
    t_phase();
    t_timer();
    t_capture();
    tally_and_finish();
  end
endmodule
